// File: src/operand_and_branch_target_former.sv
// decode-stage operand, precision and branch target former
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - logical-op immediate in first source is zero-extended to 32 bits
// - add/sub and address immediates are sign-extended
// - register-only first source always yields a register, never an immediate
// - short immediate is five bits, zero-extended to 32 bits
// - sixteen-bit offset constant is sign-extended before address addition
// - long branch offset is a signed 26-bit field
// - short branch offset is a signed 16-bit field
// - target is offset shifted two, sign-extended, plus ip plus four
// - control operand selects one of twelve control registers
// - float operand selects one of thirty-two float registers
// - integer operand selects one of thirty-two integer registers
// - precision suffix decodes to source and result precision
// - result precision never below source precision by default
// - one precision applies to both inputs
// - restricted class rejects double-to-single
// - vector operand is the sized value returned from the port
// - pixel mask is eight addressable bits, bit 0 least significant
// - direct branches execute one more sequential instruction first
module operand_and_branch_target_former
  import opform_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_ip,
  input  wire first_source_field_kind_t  i_first_source_field_kind,
  input  wire br_kind_t    i_br_kind,
  input  wire logic        i_br_direct,
  input  wire prec_t       i_prec,
  input  wire pcls_t       i_pcls,
  input  wire logic        i_ctrl_op,
  input  wire logic        i_vec_valid,
  input  wire io_size_t    i_vec_size,
  input  wire logic [31:0] i_vec_data,
  input  wire logic [7:0]  i_pm_we,
  input  wire logic [7:0]  i_pm_val,
  output logic             o_valid,
  output logic [4:0]       o_int_first_source_field,
  output logic [4:0]       o_int_second_source_field,
  output logic [4:0]       o_int_dest,
  output logic [4:0]       o_fp_first_source_field,
  output logic [4:0]       o_fp_second_source_field,
  output logic [4:0]       o_fp_dest,
  output logic             o_first_source_field_is_imm,
  output logic [31:0]      o_first_source_field_imm,
  output logic [31:0]      o_offset,
  output var ctrl_sel_t    o_ctrl_sel,
  output logic             o_ctrl_bad,
  output logic             o_src_double,
  output logic             o_res_double,
  output logic             o_prec_bad,
  output logic             o_br_valid,
  output logic [31:0]      o_br_target,
  output logic             o_br_delay_slot,
  output logic             o_vec_valid,
  output logic [31:0]      o_vec_data,
  output logic [7:0]       o_pixel_mask
);

  // ****************************************
  // field extraction
  // ****************************************
  logic [4:0]  f_first_source_field;
  logic [4:0]  f_second_source_field;
  logic [4:0]  f_dest;
  logic [15:0] f_imm;
  logic [4:0]  f_short;
  logic [25:0] f_lbr;
  logic [15:0] f_sbr;

  // register fields give 32 integer / 32 float indices directly
  assign f_first_source_field  = i_instr[FIRST_SOURCE_FIELD_LSB +: REG_W];
  assign f_second_source_field  = i_instr[SECOND_SOURCE_FIELD_LSB +: REG_W];
  assign f_dest  = i_instr[DEST_LSB +: REG_W];
  assign f_imm   = i_instr[IMM_W-1:0];
  assign f_short = i_instr[FIRST_SOURCE_FIELD_LSB +: SHORT_W];
  assign f_lbr   = i_instr[LBR_W-1:0];
  // short offset is split around the first_source_field field
  assign f_sbr   = {i_instr[SBR_HI_LSB +: REG_W], i_instr[SBR_LO_W-1:0]};

  // ****************************************
  // first source immediate
  // ****************************************
  wire [31:0] imm_zext  = {16'h0000, f_imm};
  wire [31:0] imm_sext  = {{16{f_imm[15]}}, f_imm};
  wire [31:0] short_ext = {27'h0000000, f_short};
  wire        is_logic  = (i_first_source_field_kind == FIRST_SOURCE_FIELD_LOGIC_IMM);
  wire        is_arith  = (i_first_source_field_kind == FIRST_SOURCE_FIELD_ARITH_IMM) ||
                          (i_first_source_field_kind == FIRST_SOURCE_FIELD_ADDR_IMM);
  wire        is_short  = (i_first_source_field_kind == FIRST_SOURCE_FIELD_SHORT_IMM);
  // register-only kind falls through to no immediate at all
  wire        nxt_is_imm = is_logic || is_arith || is_short;
  wire [31:0] nxt_imm   = is_logic ? imm_zext :
                          is_arith ? imm_sext :
                          is_short ? short_ext : RST_WORD;

  // address offset is always the sign-extended constant
  wire [31:0] nxt_offset = imm_sext;

  // ****************************************
  // branch target
  // ****************************************
  wire [31:0] lbr_ext  = {{4{f_lbr[25]}}, f_lbr, 2'b00};
  wire [31:0] sbr_ext  = {{14{f_sbr[15]}}, f_sbr, 2'b00};
  wire [31:0] br_off   = (i_br_kind == BR_LONG) ? lbr_ext : sbr_ext;
  // plain 32-bit adds drop the carry, so the target wraps silently
  wire [31:0] nxt_tgt  = i_ip + IP_STEP + br_off;
  wire        nxt_brv  = i_valid && (i_br_kind != BR_NONE);
  wire        nxt_dly  = nxt_brv && i_br_direct;

  // ****************************************
  // control register select
  // ****************************************
  // second_source_field field picks one of twelve; higher codes flag as bad
  wire        nxt_cbad = i_ctrl_op && (f_second_source_field >= 5'(NUM_CTRL));
  wire [3:0]  nxt_csel = nxt_cbad ? 4'h0 : f_second_source_field[3:0];

  // ****************************************
  // precision
  // ****************************************
  // a single suffix covers both inputs, so mixed sources cannot exist
  wire        nxt_sdbl = (i_prec == PREC_DD) || (i_prec == PREC_DS);
  wire        nxt_rdbl = (i_prec == PREC_SD) || (i_prec == PREC_DD);
  // only the explicit rounding-move class may narrow the result
  wire        bad_p    = (i_pcls == PCLS_P) && (i_prec == PREC_DS);
  wire        bad_v    = (i_pcls == PCLS_V) &&
                         !((i_prec == PREC_SD) || (i_prec == PREC_DD));
  wire        bad_w    = (i_pcls == PCLS_W) &&
                         !((i_prec == PREC_SS) || (i_prec == PREC_DD));
  wire        nxt_pbad = bad_p || bad_v || bad_w;

  // ****************************************
  // interrupt vector sizing
  // ****************************************
  wire [31:0] nxt_vec  = (i_vec_size == SZ_BYTE) ? {24'h000000, i_vec_data[7:0]} :
                         (i_vec_size == SZ_HALF) ? {16'h0000, i_vec_data[15:0]} :
                         i_vec_data;

  // ****************************************
  // output registers
  // ****************************************
  // decode results, one cycle after the instruction
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_valid       <= 1'b0;
      o_int_first_source_field    <= 5'h00;
      o_int_second_source_field    <= 5'h00;
      o_int_dest    <= 5'h00;
      o_fp_first_source_field     <= 5'h00;
      o_fp_second_source_field     <= 5'h00;
      o_fp_dest     <= 5'h00;
      o_first_source_field_is_imm <= 1'b0;
      o_first_source_field_imm    <= RST_WORD;
      o_offset      <= RST_WORD;
    end
    else
    begin
      o_valid       <= i_valid;
      o_int_first_source_field    <= f_first_source_field;
      o_int_second_source_field    <= f_second_source_field;
      o_int_dest    <= f_dest;
      o_fp_first_source_field     <= f_first_source_field;
      o_fp_second_source_field     <= f_second_source_field;
      o_fp_dest     <= f_dest;
      o_first_source_field_is_imm <= i_valid && nxt_is_imm;
      o_first_source_field_imm    <= nxt_imm;
      o_offset      <= nxt_offset;
    end
  end

  // control, precision and branch results
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_ctrl_sel      <= CR_FAULT_IP;
      o_ctrl_bad      <= 1'b0;
      o_src_double    <= 1'b0;
      o_res_double    <= 1'b0;
      o_prec_bad      <= 1'b0;
      o_br_valid      <= 1'b0;
      o_br_target     <= RST_WORD;
      o_br_delay_slot <= 1'b0;
    end
    else
    begin
      o_ctrl_sel      <= ctrl_sel_t'(nxt_csel);
      o_ctrl_bad      <= i_valid && nxt_cbad;
      o_src_double    <= nxt_sdbl;
      o_res_double    <= nxt_rdbl;
      o_prec_bad      <= i_valid && nxt_pbad;
      o_br_valid      <= nxt_brv;
      o_br_target     <= nxt_tgt;
      o_br_delay_slot <= nxt_dly;
    end
  end

  // vector capture; only the requested size reaches the operand
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_vec_valid <= 1'b0;
      o_vec_data  <= RST_WORD;
    end
    else
    begin
      o_vec_valid <= i_vec_valid;
      if (i_vec_valid)
        o_vec_data <= nxt_vec;
    end
  end

  // ****************************************
  // pixel mask
  // ****************************************
  pixel_mask_reg u_pm (
    .i_mclk       (i_mclk),
    .i_srst       (i_srst),
    .i_bit_we     (i_pm_we),
    .i_bit_val    (i_pm_val),
    .o_pixel_mask (o_pixel_mask)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_logic_zext: assert property (i_valid && is_logic |=> o_first_source_field_imm[31:16] == 16'h0000 && o_first_source_field_is_imm)
    else $error("logical immediate not zero-extended");
  a_arith_sext: assert property (i_valid && is_arith |=> o_first_source_field_imm == {{16{$past(f_imm[15])}}, $past(f_imm)})
    else $error("arith immediate not sign-extended");
  a_regonly_noimm: assert property (i_valid && i_first_source_field_kind == FIRST_SOURCE_FIELD_REG_ONLY |=> !o_first_source_field_is_imm)
    else $error("register-only source gave an immediate");
  a_short_zext: assert property (i_valid && is_short |=> o_first_source_field_imm[31:5] == 27'h0)
    else $error("short immediate above bit 4");
  a_offset_sext: assert property (1 |=> o_offset[31:16] == {16{o_offset[15]}})
    else $error("offset not sign-extended");
  a_target_long: assert property (i_valid && i_br_kind == BR_LONG |=>
      o_br_target == $past(i_ip) + 32'h4 + {{4{$past(i_instr[25])}}, $past(i_instr[25:0]), 2'b00})
    else $error("long target wrong");
  a_target_align: assert property (o_br_valid |-> o_br_target[1:0] == $past(i_ip[1:0]))
    else $error("target alignment wrong");
  a_delay_slot: assert property (o_br_delay_slot |-> o_br_valid)
    else $error("delay slot without branch");
  a_ctrl_range: assert property (i_valid && i_ctrl_op && f_second_source_field >= 5'd12 |=> o_ctrl_bad)
    else $error("bad control selector accepted");
  a_prec_ds_p: assert property (i_valid && i_pcls == PCLS_P && i_prec == PREC_DS |=> o_prec_bad)
    else $error("double-to-single accepted in restricted class");
  a_pm_write: assert property (i_pm_we[0] |=> o_pixel_mask[0] == $past(i_pm_val[0]))
    else $error("pixel mask bit 0 not written");
  a_pm_keep: assert property (!i_pm_we[7] |=> o_pixel_mask[7] == $past(o_pixel_mask[7]))
    else $error("pixel mask bit 7 changed without enable");
  a_int_fields: assert property (1 |=> o_int_first_source_field == $past(f_first_source_field) && o_int_dest == $past(f_dest))
    else $error("integer register field wrong");
  a_fp_fields: assert property (1 |=> o_fp_second_source_field == $past(f_second_source_field) && o_fp_dest == $past(f_dest))
    else $error("float register field wrong");
  a_target_short: assert property (i_valid && i_br_kind == BR_SHORT |=>
      o_br_target == $past(i_ip) + 32'h4 + {{14{$past(i_instr[20])}}, $past(i_instr[20:16]),
                                            $past(i_instr[10:0]), 2'b00})
    else $error("short target wrong");
  a_res_prec: assert property (1 |=> o_res_double == ($past(i_prec) == PREC_SD ||
                                                      $past(i_prec) == PREC_DD))
    else $error("result precision wrong");
  a_src_prec: assert property (1 |=> o_src_double == ($past(i_prec) == PREC_DD ||
                                                      $past(i_prec) == PREC_DS))
    else $error("source precision wrong");
  a_vec_byte: assert property (i_vec_valid && i_vec_size == SZ_BYTE |=> o_vec_data[31:8] == 24'h0)
    else $error("byte vector not zero-extended");

  c_long_br:  cover property (i_valid && i_br_kind == BR_LONG && i_br_direct);
  c_short_br: cover property (i_valid && i_br_kind == BR_SHORT);
  c_prec_bad: cover property (o_prec_bad);
  c_vec:      cover property (o_vec_valid);
  c_ctrl_bad: cover property (o_ctrl_bad);

endmodule
`default_nettype wire

// File: src/opform_pkg.sv
// constants and types shared by the operand and branch target former
package opform_pkg;

  // ****************************************
  // instruction word fields
  // ****************************************
  localparam int unsigned SECOND_SOURCE_FIELD_LSB  = 21;
  localparam int unsigned DEST_LSB  = 16;
  localparam int unsigned FIRST_SOURCE_FIELD_LSB  = 11;
  localparam int unsigned REG_W     = 5;
  localparam int unsigned IMM_W     = 16;
  localparam int unsigned SHORT_W   = 5;
  localparam int unsigned LBR_W     = 26;
  localparam int unsigned SBR_HI_LSB = 16;
  localparam int unsigned SBR_LO_W  = 11;
  localparam int unsigned BR_SHIFT  = 2;
  localparam logic [31:0] IP_STEP   = 32'h0000_0004;
  localparam int unsigned NUM_CTRL  = 12;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  RST_MASK  = 8'h00;

  // immediate handling of the first source field
  typedef enum logic [2:0] {
    FIRST_SOURCE_FIELD_REG,
    FIRST_SOURCE_FIELD_LOGIC_IMM,
    FIRST_SOURCE_FIELD_ARITH_IMM,
    FIRST_SOURCE_FIELD_ADDR_IMM,
    FIRST_SOURCE_FIELD_REG_ONLY,
    FIRST_SOURCE_FIELD_SHORT_IMM
  } first_source_field_kind_t;

  // branch offset width
  typedef enum logic [1:0] {
    BR_NONE,
    BR_LONG,
    BR_SHORT
  } br_kind_t;

  // precision suffix
  typedef enum logic [1:0] {
    PREC_SS,
    PREC_SD,
    PREC_DD,
    PREC_DS
  } prec_t;

  // precision class that an operation accepts
  typedef enum logic [1:0] {
    PCLS_R,
    PCLS_P,
    PCLS_V,
    PCLS_W
  } pcls_t;

  // control register selector
  typedef enum logic [3:0] {
    CR_FAULT_IP,
    CR_STATUS,
    CR_EXT_STATUS,
    CR_DIR_BASE,
    CR_DEBUG_REG,
    CR_FP_STATUS,
    CR_BUS_ERR_ADDR,
    CR_CONC_CTRL,
    CR_SCRATCH0,
    CR_SCRATCH1,
    CR_SCRATCH2,
    CR_SCRATCH3
  } ctrl_sel_t;

  // access size of a port / vector read
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_HALF,
    SZ_WORD
  } io_size_t;

endpackage

// File: src/pixel_mask_reg.sv
// eight-bit pixel mask register with per-bit write enables
`timescale 1ns/100ps
`default_nettype none
module pixel_mask_reg
  import opform_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_bit_we,
  input  wire logic [7:0] i_bit_val,
  output logic      [7:0] o_pixel_mask
);

  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;

  // each bit is written on its own; index 0 is the lsb
  assign nxt_mask = (i_bit_we & i_bit_val) | (~i_bit_we & mask_ff);

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      mask_ff <= RST_MASK;
    else
      mask_ff <= nxt_mask;
  end

  assign o_pixel_mask = mask_ff;

endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the operand and branch target former
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
      fail_count++; \
    end \
  end
module testbench
  import opform_pkg::*;
;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_valid = 1'b0;
  logic [31:0] i_instr = 32'h0;
  logic [31:0] i_ip = 32'h0;
  first_source_field_kind_t  i_first_source_field_kind = FIRST_SOURCE_FIELD_REG;
  br_kind_t    i_br_kind = BR_NONE;
  logic        i_br_direct = 1'b0;
  prec_t       i_prec = PREC_SS;
  pcls_t       i_pcls = PCLS_R;
  logic        i_ctrl_op = 1'b0;
  logic        i_vec_valid = 1'b0;
  io_size_t    i_vec_size = SZ_BYTE;
  logic [31:0] i_vec_data = 32'h0;
  logic [7:0]  i_pm_we = 8'h0;
  logic [7:0]  i_pm_val = 8'h0;
  logic        o_valid, o_first_source_field_is_imm, o_ctrl_bad, o_src_double, o_res_double;
  logic        o_prec_bad, o_br_valid, o_br_delay_slot, o_vec_valid;
  logic [4:0]  o_int_first_source_field, o_int_second_source_field, o_int_dest, o_fp_first_source_field, o_fp_second_source_field, o_fp_dest;
  logic [31:0] o_first_source_field_imm, o_offset, o_br_target, o_vec_data;
  logic [7:0]  o_pixel_mask;
  ctrl_sel_t   o_ctrl_sel;
  int          fail_count = 0;
  int          cmp_count = 0;

  // 4 ns clock, one output cycle of latency throughout
  always #2 i_mclk = ~i_mclk;

  operand_and_branch_target_former i_dut (.*);

  // ****************************************
  // shared helpers
  // ****************************************
  // sample just after the edge so registered outputs have landed
  task automatic settle();
    @(posedge i_mclk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset must win over a live instruction and clear held state
  task automatic reset_case();
    @(posedge i_mclk);
    i_srst <= 1'b1;
    i_valid <= 1'b1;
    i_br_kind <= BR_LONG;
    settle();
    `CHK("reset o_valid", 1'b0, o_valid);
    `CHK("reset o_br_valid", 1'b0, o_br_valid);
    `CHK("reset o_pixel_mask", 8'h00, o_pixel_mask);
    `CHK("reset o_vec_data", 32'h0, o_vec_data);
    @(posedge i_mclk);
    i_srst <= 1'b0;
    i_br_kind <= BR_NONE;
  endtask

  // every first source kind against one negative immediate
  task automatic first_source_field_case();
    for (int k = 0; k < 6; k++)
    begin
      @(posedge i_mclk);
      i_valid <= 1'b1;
      i_instr <= 32'h03e0_8a5c;
      i_first_source_field_kind <= first_source_field_kind_t'(k);
      settle();
      `CHK("o_valid", 1'b1, o_valid);
      `CHK("o_int_second_source_field", 5'd31, o_int_second_source_field);
      `CHK("o_int_dest", 5'd0, o_int_dest);
      `CHK("o_fp_first_source_field", 5'd17, o_fp_first_source_field);
      `CHK("o_fp_second_source_field", 5'd31, o_fp_second_source_field);
      `CHK("o_offset", 32'hffff_8a5c, o_offset);
      if (k == 1) `CHK("logic imm", 32'h0000_8a5c, o_first_source_field_imm);
      if (k == 2 || k == 3) `CHK("arith imm", 32'hffff_8a5c, o_first_source_field_imm);
      if (k == 4) `CHK("reg only imm flag", 1'b0, o_first_source_field_is_imm);
      if (k == 4) `CHK("reg only first_source_field", 5'd17, o_int_first_source_field);
      if (k == 5) `CHK("short imm", 32'h0000_0011, o_first_source_field_imm);
    end
  endtask

  // twelve valid selectors, then out-of-range ones
  task automatic ctrl_case();
    for (int i = 0; i < 15; i++)
    begin
      @(posedge i_mclk);
      i_ctrl_op <= (i != 14);
      i_instr <= {6'h0, i[4:0] - ((i == 14) ? 5'd1 : 5'd0), 21'h0};
      settle();
      `CHK("o_ctrl_sel", (i == 14) ? ctrl_sel_t'(13) : (i < 12) ? ctrl_sel_t'(i) : CR_FAULT_IP, o_ctrl_sel);
      `CHK("o_ctrl_bad", (i == 12 || i == 13), o_ctrl_bad);
    end
    i_ctrl_op <= 1'b0;
  endtask

  // all suffixes under all precision classes
  task automatic prec_case();
    logic bad;
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 4; p++)
      begin
        @(posedge i_mclk);
        i_prec <= prec_t'(p);
        i_pcls <= pcls_t'(c);
        settle();
        bad = (c == 1 && p == 3) || (c == 2 && (p == 0 || p == 3)) || (c == 3 && p[0]);
        `CHK("o_src_double", (p >= 2), o_src_double);
        `CHK("o_res_double", (p == 1 || p == 2), o_res_double);
        `CHK("o_prec_bad", bad, o_prec_bad);
      end
  endtask

  task automatic br_case(input br_kind_t kd, input logic [31:0] ins, input logic [31:0] ip,
                         input logic dir, input logic [31:0] exp);
    @(posedge i_mclk);
    i_br_kind <= kd;
    i_instr <= ins;
    i_ip <= ip;
    i_br_direct <= dir;
    settle();
    `CHK("o_br_valid", (kd != BR_NONE), o_br_valid);
    if (kd != BR_NONE) `CHK("o_br_target", exp, o_br_target);
    `CHK("o_br_delay_slot", (kd != BR_NONE) && dir, o_br_delay_slot);
  endtask

  // sized vector reads, then the held value once the strobe drops
  task automatic vec_case();
    for (int s = 0; s < 3; s++)
    begin
      @(posedge i_mclk);
      i_vec_valid <= 1'b1;
      i_vec_size <= io_size_t'(s);
      i_vec_data <= 32'hffff_ffa5;
      settle();
      `CHK("o_vec_valid", 1'b1, o_vec_valid);
      `CHK("o_vec_data", (s == 0) ? 32'ha5 : (s == 1) ? 32'hffa5 : 32'hffff_ffa5, o_vec_data);
    end
    @(posedge i_mclk);
    i_vec_valid <= 1'b0;
    i_vec_data <= 32'h0;
    settle();
    `CHK("o_vec_valid low", 1'b0, o_vec_valid);
    `CHK("o_vec_data held", 32'hffff_ffa5, o_vec_data);
  endtask

  // per-bit writes leave the other bits alone
  task automatic pm_case();
    logic [7:0] we[4] = '{8'h01, 8'h80, 8'h7e, 8'h01};
    logic [7:0] vl[4] = '{8'hff, 8'hff, 8'h2a, 8'h00};
    logic [7:0] ex[4] = '{8'h01, 8'h81, 8'hab, 8'haa};
    for (int n = 0; n < 4; n++)
    begin
      @(posedge i_mclk);
      i_pm_we <= we[n];
      i_pm_val <= vl[n];
      settle();
      `CHK("o_pixel_mask", ex[n], o_pixel_mask);
    end
    @(posedge i_mclk);
    i_pm_we <= 8'h00;
    settle();
    `CHK("o_pixel_mask held", 8'haa, o_pixel_mask);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_srst <= 1'b0;
    first_source_field_case();
    ctrl_case();
    prec_case();
    br_case(BR_LONG, 32'h03ff_ffff, 32'h0000_1000, 1'b1, 32'h0000_1000);
    br_case(BR_LONG, 32'h0200_0000, 32'h0000_0010, 1'b0, 32'hf800_0014);
    br_case(BR_SHORT, 32'h03f0_f800, 32'h0010_0000, 1'b1, 32'h000e_0004);
    br_case(BR_SHORT, 32'h000f_07ff, 32'hffff_fff0, 1'b0, 32'h0001_fff0);
    br_case(BR_NONE, 32'h03ff_ffff, 32'h0000_1000, 1'b1, 32'h0);
    vec_case();
    pm_case();
    reset_case();
    report_and_stop();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
